// file: hdl/rom_access_pkg.sv
// Constants shared by the serial configuration memory access block.
package rom_access_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h70;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h74;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h78;
  localparam int BIT_START  = 0;
  localparam int BIT_WRITE  = 1;
  localparam int BIT_ERR    = 2;
  localparam int BIT_DONE   = 3;
  localparam int DIV_LO     = 4;
  localparam int DIV_HI     = 5;
  localparam int BIT_ALDIS  = 6;
  localparam int BIT_FAST   = 7;
  localparam int BIT_BUSY   = 8;
  localparam int WADR_LO    = 9;
  localparam int WADR_HI    = 15;
  localparam int DATA_LO    = 16;
  localparam int DATA_HI    = 31;
  localparam logic FAST_RST = 1'b1;
  localparam int FAST_SHIFT = 5;
  localparam logic [12:0] DIV_SEL0 = 13'h1000;
  localparam logic [12:0] DIV_SEL1 = 13'h0800;
  localparam logic [12:0] DIV_SEL2 = 13'h0400;
  localparam logic [12:0] DIV_SEL3 = 13'h0080;
  localparam logic [7:0] DEV_SEL = 8'ha0;
  localparam int IRQ_W = 3;
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_LD_DONE = 1;
  localparam int IRQ_ERR     = 2;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOAD} op_t;

  // Half period of the serial clock in core cycles for a given select.
  function automatic logic [12:0] half_period(input logic [1:0] sel, input logic fast);
    logic [12:0] full;
    full = DIV_SEL0;
    case (sel)
      2'h0: full = DIV_SEL0;
      2'h1: full = DIV_SEL1;
      2'h2: full = DIV_SEL2;
      default: full = DIV_SEL3;
    endcase
    if (fast)
      half_period = full >> (FAST_SHIFT + 1);
    else
      half_period = full >> 1;
  endfunction : half_period
endpackage : rom_access_pkg

// file: hdl/rom_link_if.sv
// Bundle between the access controller and its serial engine.
`timescale 1ns/1ps
`default_nettype none
interface rom_link_if;
  logic        go;
  rom_access_pkg::op_t op;
  logic [6:0]  wadr;
  logic [15:0] wdata;
  logic [12:0] half;
  logic        done;
  logic        nak;
  logic [15:0] rdata;
  modport ctrl (output go, output op, output wadr, output wdata, output half,
                input done, input nak, input rdata);
  modport eng  (input go, input op, input wadr, input wdata, input half,
                output done, output nak, output rdata);
endinterface : rom_link_if
`default_nettype wire

// file: hdl/rom_serial_engine.sv
// Two-wire serial engine: one word read or write per request.
`timescale 1ns/1ps
`default_nettype none
module rom_serial_engine
(
  input  wire logic clk_sys,
  input  wire logic srst,
  rom_link_if.eng   lk,
  output logic      scl_o,
  input  wire logic sda_i,
  output logic      sda_oe
);
  typedef enum {S_IDLE, S_START, S_BIT, S_STOP} st_t;
  st_t         st_r;
  logic [12:0] tick_r;
  logic [1:0]  ph_r;
  logic [5:0]  nbit_r;
  logic [5:0]  pos_r;
  logic [44:0] frame_r;
  logic [44:0] ackm_r;
  logic        nak_r;
  logic        rdop_r;
  logic [15:0] rd_r;
  logic        tick;
  logic        rd_bit;

  assign tick   = (tick_r == 13'h0001);
  assign rd_bit = rdop_r && (pos_r >= 6'd18);

  // Quarter-phase timer derived from the half period.
  always_ff @(posedge clk_sys)
  begin
    if (srst || st_r == S_IDLE || tick)
      tick_r <= ((lk.half >> 1) == 13'h0000) ? 13'h0001 : (lk.half >> 1);
    else
      tick_r <= tick_r - 13'h0001;
  end

  // Frame: device, address, then data bytes; acknowledge slots set as release.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= S_IDLE; ph_r <= 2'h0; pos_r <= 6'h00; nbit_r <= 6'h00;
      frame_r <= '0; ackm_r <= '0; nak_r <= 1'b0; rd_r <= 16'h0000;
      scl_o <= 1'b1; sda_oe <= 1'b0; lk.done <= 1'b0;
      rdop_r <= 1'b0;
    end
    else
    begin
      lk.done <= 1'b0;
      case (st_r)
        S_IDLE:
          if (lk.go)
          begin
            // Reads flag bit 7 of the address byte and release both data bytes.
            rdop_r  <= (lk.op != rom_access_pkg::OP_WRITE);
            frame_r <= {rom_access_pkg::DEV_SEL, 1'b1, (lk.op != rom_access_pkg::OP_WRITE),
                        lk.wadr, 1'b1,
                        (lk.op == rom_access_pkg::OP_WRITE) ? lk.wdata[15:8] : 8'hff, 1'b1,
                        (lk.op == rom_access_pkg::OP_WRITE) ? lk.wdata[7:0] : 8'hff, 1'b1,
                        9'h1ff};
            ackm_r  <= {9'h001, 9'h001, 9'h001, 9'h001, 9'h000};
            nbit_r  <= 6'd36;
            pos_r <= 6'h00; nak_r <= 1'b0; st_r <= S_START; sda_oe <= 1'b1;
          end
        S_START:
          if (tick) begin scl_o <= 1'b0; ph_r <= 2'h0; st_r <= S_BIT; end
        S_BIT:
          if (tick)
          begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe <= ~frame_r[6'd44 - pos_r]; // Ones release the line.
              2'h1: scl_o <= 1'b1;
              2'h2:
              begin
                if (ackm_r[6'd44 - pos_r] && sda_i && pos_r < 6'd36)
                  nak_r <= 1'b1;
                if (rd_bit && !ackm_r[6'd44 - pos_r])
                  rd_r <= {rd_r[14:0], sda_i};
              end
              default:
              begin
                scl_o <= 1'b0;
                pos_r <= pos_r + 6'h01;
                if (pos_r + 6'h01 == nbit_r) begin st_r <= S_STOP; sda_oe <= 1'b1; end
              end
            endcase
          end
        default:
          if (tick)
          begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) scl_o <= 1'b1;
            if (ph_r == 2'h1)
            begin
              sda_oe <= 1'b0; lk.done <= 1'b1; st_r <= S_IDLE;
            end
          end
      endcase
    end
  end
  assign lk.nak   = nak_r;
  assign lk.rdata = rd_r;
endmodule : rom_serial_engine
`default_nettype wire

// file: hdl/rom_access_ctrl.sv
// Control/status register, automatic load sequencer and interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module rom_access_ctrl
#(
  parameter int LOAD_WORDS = 16
)
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  output logic             scl_o,
  input  wire logic        sda_i,
  output logic             sda_oe,
  output logic             load_valid,
  output logic [6:0]       load_wadr,
  output logic [15:0]      load_data
);
  // The word counter is seven bits wide, so larger loads cannot be served.
  if (LOAD_WORDS < 1 || LOAD_WORDS > 128)
  begin : g_bad_load_words
    $error("LOAD_WORDS must lie in 1..128");
  end

  rom_link_if lk ();

  logic        start_r;
  logic        wrcmd_r;
  logic        err_r;
  logic        done_r;
  logic [1:0]  div_r;
  logic        aldis_r;
  logic        fast_r;
  logic        busy_r;
  logic [6:0]  wadr_r;
  logic [15:0] data_r;
  logic [2:0]  ist_r;
  logic [2:0]  imk_r;
  logic        active_r;
  logic        autold_r;
  logic        pend_r;
  logic [6:0]  lcnt_r;
  logic        ld_err_r;
  logic        wr_ctrl;
  logic        start_rise;
  logic [2:0]  ev;

  assign wr_ctrl    = reg_wr && (reg_addr == rom_access_pkg::ADDR_CTRL);
  assign start_rise = wr_ctrl && reg_wdata[rom_access_pkg::BIT_START] && !start_r;

  // Software-owned fields, latched from the bus; a finished read also loads the data field.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wrcmd_r <= 1'b0; div_r <= 2'h0; aldis_r <= 1'b0;
      fast_r <= rom_access_pkg::FAST_RST; wadr_r <= 7'h00; data_r <= 16'h0000;
    end
    else if (wr_ctrl)
    begin
      wrcmd_r <= reg_wdata[rom_access_pkg::BIT_WRITE];
      div_r   <= reg_wdata[rom_access_pkg::DIV_HI:rom_access_pkg::DIV_LO];
      aldis_r <= reg_wdata[rom_access_pkg::BIT_ALDIS];
      fast_r  <= reg_wdata[rom_access_pkg::BIT_FAST];
      wadr_r  <= reg_wdata[rom_access_pkg::WADR_HI:rom_access_pkg::WADR_LO];
      data_r  <= reg_wdata[rom_access_pkg::DATA_HI:rom_access_pkg::DATA_LO];
    end
    else if (lk.done && active_r && !autold_r && !wrcmd_r)
      data_r <= lk.rdata; // Read result lands in the data field.
  end

  // Start bit: set by a software rising write, cleared by hardware at the end.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      start_r <= 1'b0;
    else if (start_rise)
      start_r <= 1'b1;
    else if (lk.done && active_r && !autold_r)
      start_r <= 1'b0;
    else if (wr_ctrl && !reg_wdata[rom_access_pkg::BIT_START] && !active_r)
      start_r <= 1'b0;
  end

  // Automatic load: arms after reset unless software disables it first.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pend_r <= 1'b1; busy_r <= 1'b0; lcnt_r <= 7'h00; ld_err_r <= 1'b0; done_r <= 1'b0;
    end
    else if (pend_r && !active_r)
    begin
      pend_r <= 1'b0;
      // A disable written in this very cycle must still stop the load.
      busy_r <= !(wr_ctrl ? reg_wdata[rom_access_pkg::BIT_ALDIS] : aldis_r);
      lcnt_r <= 7'h00;
      ld_err_r <= 1'b0;
    end
    else if (busy_r && lk.done && autold_r)
    begin
      ld_err_r <= ld_err_r | lk.nak;
      lcnt_r <= lcnt_r + 7'h01;
      if (lcnt_r == 7'(LOAD_WORDS - 1))
      begin
        busy_r <= 1'b0;
        done_r <= !(ld_err_r | lk.nak);
      end
    end
  end

  // Issue engine requests; the load has priority over a software access.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      active_r <= 1'b0; autold_r <= 1'b0;
    end
    else if (active_r)
    begin
      if (lk.done) active_r <= 1'b0;
    end
    else if (busy_r && !pend_r)
    begin
      active_r <= 1'b1; autold_r <= 1'b1;
    end
    else if (start_r && !start_rise)
    begin
      active_r <= 1'b1; autold_r <= 1'b0;
    end
  end

  assign lk.go    = !active_r && ((busy_r && !pend_r) || (start_r && !start_rise));
  assign lk.op    = (busy_r && !pend_r) ? rom_access_pkg::OP_LOAD :
                    (wrcmd_r ? rom_access_pkg::OP_WRITE : rom_access_pkg::OP_READ);
  assign lk.wadr  = (busy_r && !pend_r) ? lcnt_r : wadr_r;
  assign lk.wdata = data_r;
  assign lk.half  = rom_access_pkg::half_period(div_r, fast_r && busy_r);

  // Error flag: any missing acknowledge during a cycle sets it until the next start.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      err_r <= 1'b0;
    else if (lk.done && lk.nak)
      err_r <= 1'b1;
    else if (lk.go)
      err_r <= 1'b0;
  end

  // Loaded words are handed out as they arrive.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      load_valid <= 1'b0; load_wadr <= 7'h00; load_data <= 16'h0000;
    end
    else
    begin
      load_valid <= lk.done && autold_r && active_r && !lk.nak;
      load_wadr  <= lcnt_r;
      load_data  <= lk.rdata;
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins over a clear.
  assign ev[rom_access_pkg::IRQ_OP_DONE] = lk.done && active_r && !autold_r;
  assign ev[rom_access_pkg::IRQ_LD_DONE] = lk.done && autold_r &&
                                            lcnt_r == 7'(LOAD_WORDS - 1);
  assign ev[rom_access_pkg::IRQ_ERR]     = lk.done && lk.nak;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ist_r <= 3'h0; imk_r <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == rom_access_pkg::ADDR_IRQ_ST)
        ist_r <= (ist_r & ~reg_wdata[2:0]) | ev;
      else
        ist_r <= ist_r | ev;
      if (reg_wr && reg_addr == rom_access_pkg::ADDR_IRQ_MK)
        imk_r <= reg_wdata[2:0];
    end
  end
  assign irq = |(ist_r & imk_r);

  // Read data appear the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else if (reg_addr == rom_access_pkg::ADDR_CTRL)
      reg_rdata <= {data_r, wadr_r, busy_r, fast_r, aldis_r, div_r,
                    done_r, err_r, wrcmd_r, start_r};
    else if (reg_addr == rom_access_pkg::ADDR_IRQ_ST)
      reg_rdata <= {29'h0, ist_r};
    else if (reg_addr == rom_access_pkg::ADDR_IRQ_MK)
      reg_rdata <= {29'h0, imk_r};
    else
      reg_rdata <= 32'h0000_0000;
  end

  rom_serial_engine u_engine
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .lk      (lk),
    .scl_o   (scl_o),
    .sda_i   (sda_i),
    .sda_oe  (sda_oe)
  );
endmodule : rom_access_ctrl
`default_nettype wire

// file: verification/rom_eeprom_model.sv
// Behavioural two-wire serial memory standing on the far side of the link.
`timescale 1ns/1ps
`default_nettype none
module rom_eeprom_model
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      pull_low
);
  logic [15:0] mem [128];
  logic [15:0] sh;
  logic [7:0]  adr;
  int          idx;
  // Contents follow a pattern the bench also knows, so every read can be predicted.
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 16'(i * 333 + 4660);
    idx = -1;
    pull_low = 1'b0;
  end
  // Start and stop are data edges while the clock is high.
  always @(negedge sda)
    if (scl)
      idx = 0;
  always @(posedge sda)
    if (scl)
      idx = -1;
  // Bits are taken on the rising clock; a write lands after its last data bit.
  always @(posedge scl)
  begin
    if (idx >= 9 && idx <= 16)
      adr = {adr[6:0], sda};
    if ((idx >= 18 && idx <= 25) || (idx >= 27 && idx <= 34))
      sh = {sh[14:0], sda};
    if (idx == 34 && !adr[7])
      mem[adr[6:0]] = sh;
    if (idx >= 0)
      idx++;
  end
  // Change the drive only on the falling clock, so no false start or stop is ever made.
  always @(negedge scl)
  begin
    pull_low = 1'b0;
    if (idx == 8 || idx == 17 || idx == 26 || idx == 35)
      pull_low = ack_en;
    else if (adr[7] && idx >= 18 && idx <= 25)
      pull_low = !mem[adr[6:0]][33 - idx];
    else if (adr[7] && idx >= 27 && idx <= 34)
      pull_low = !mem[adr[6:0]][34 - idx];
  end
endmodule : rom_eeprom_model
`default_nettype wire

// file: verification/rom_access_ctrl_monitor.sv
// Port-level checker for the serial memory access controller.
`timescale 1ns/1ps
`default_nettype none
module rom_access_ctrl_monitor
#(
  parameter int LOAD_WORDS = 16
)
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq,
  input wire logic        scl_o,
  input wire logic        sda_i,
  input wire logic        sda_oe,
  input wire logic        load_valid,
  input wire logic [6:0]  load_wadr,
  input wire logic [15:0] load_data
);
  logic [2:0] mask_r;
  // Shadow of the mask, so the interrupt line can be tied to a status read.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mask_r <= 3'h0;
    else if (reg_wr && reg_addr == rom_access_pkg::ADDR_IRQ_MK)
      mask_r <= reg_wdata[2:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_rd(a);
    reg_rd && reg_addr == a ##1 1'b1;
  endsequence
  property p_rd_zero;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
  property p_scl_hold;
    $changed(scl_o) |=> $stable(scl_o);
  endproperty
  a_scl_hold: assert property (p_scl_hold) else $error("serial clock too fast");
  property p_rst_idle;
    $fell(srst) |-> scl_o && !sda_oe && !load_valid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_load_pulse;
    load_valid |=> !load_valid;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
  property p_load_adr;
    load_valid |-> load_wadr < LOAD_WORDS;
  endproperty
  a_load_adr: assert property (p_load_adr) else $error("load address out of range");
  property p_busy_done;
    s_rd(rom_access_pkg::ADDR_CTRL) |-> !(reg_rdata[8] && reg_rdata[3]);
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done while loading");
  property p_link_idle;
    s_rd(rom_access_pkg::ADDR_CTRL) |-> reg_rdata[0] || reg_rdata[8]
      || ($past(scl_o) && !$past(sda_oe));
  endproperty
  a_link_idle: assert property (p_link_idle) else $error("start clear, link busy");
  property p_irq;
    s_rd(rom_access_pkg::ADDR_IRQ_ST) |-> $past(irq) == |(reg_rdata[2:0] & $past(mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line disagrees with status");
endmodule : rom_access_ctrl_monitor
bind rom_access_ctrl rom_access_ctrl_monitor #(.LOAD_WORDS(LOAD_WORDS)) u_rom_access_ctrl_monitor
(
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_o(scl_o),
  .sda_i(sda_i), .sda_oe(sda_oe), .load_valid(load_valid), .load_wadr(load_wadr),
  .load_data(load_data)
);
`default_nettype wire

// file: verification/serial_eeprom_access_control_bench.sv
// Self-checking bench for the serial memory access controller.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_access_control_bench;
  localparam int LW = 2;
  logic        clk_sys, srst, reg_wr, reg_rd, irq, scl_o, sda_oe, load_valid, pull_low, ack_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [6:0]  load_wadr, wa;
  logic [15:0] load_data, wd;
  wire         sda_w = !(sda_oe || pull_low);
  int          fail_count, checked, loads, cyc, seed;
  int          exp_mem [128];
  rom_access_ctrl #(.LOAD_WORDS(LW)) u_rom_access_ctrl
  (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_o(scl_o),
    .sda_i(sda_w), .sda_oe(sda_oe), .load_valid(load_valid), .load_wadr(load_wadr),
    .load_data(load_data)
  );
  rom_eeprom_model u_rom_eeprom_model
  (
    .scl(scl_o), .sda(sda_w), .ack_en(ack_en), .pull_low(pull_low)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Loaded words are checked as they appear; the cycle ceiling cuts a hang short.
  always @(posedge clk_sys)
  begin
    #1;
    cyc++;
    if (load_valid === 1'b1)
    begin
      chk("load_data", 32'(load_data), 32'(16'(exp_mem[load_wadr])));
      loads++;
    end
    if (cyc == 90000)
    begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] cw(input logic c, input logic [6:0] a, input logic [15:0] d,
                                     input logic [1:0] s, input logic st);
    cw = {d, a, 3'b010, s, 2'b00, c, st};
  endfunction : cw
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic wait_clr;
    do rd(rom_access_pkg::ADDR_CTRL);
    while (v[0] !== 1'b0 || v[8] !== 1'b0);
  endtask : wait_clr
  // The first rises of a frame are skipped, then one whole serial period is timed.
  task automatic per(input int exp);
    longint t0;
    repeat (2) @(posedge scl_o);
    t0 = $time;
    @(posedge scl_o);
    chk("scl_period", 32'(($time - t0) / 5), 32'(exp));
  endtask : per
  // Fields go in before the start bit, and nothing moves until it clears.
  task automatic op(input logic c, input logic [6:0] a, input logic [15:0] d);
    wr(rom_access_pkg::ADDR_CTRL, cw(c, a, d, 2'h3, 1'b0));
    wr(rom_access_pkg::ADDR_CTRL, cw(c, a, d, 2'h3, 1'b1));
    per(128);
    wait_clr();
    if (c)
      exp_mem[a] = d;
    chk("ctrl_op", v, cw(c, a, 16'(exp_mem[a]), 2'h3, 1'b0) | 32'h8);
  endtask : op
  task automatic do_reset(input logic [31:0] first);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    if (first != 32'h0)
    begin
      reg_addr <= rom_access_pkg::ADDR_CTRL;
      reg_wdata <= first;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask : do_reset
  // Main sequence: automatic load, interrupt, accesses, refused ack, divider codes.
  initial
  begin
    seed = 32'he54bd576;
    for (int i = 0; i < 128; i++)
      exp_mem[i] = 16'(i * 333 + 4660);
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ack_en = 1'b1;
    do_reset(32'h0);
    rd(rom_access_pkg::ADDR_CTRL);
    chk("ctrl_rst", v, 32'h180);
    per(128);
    wait_clr();
    chk("ctrl_load", v, 32'h88);
    chk("loads", loads, LW);
    rd(rom_access_pkg::ADDR_IRQ_ST);
    chk("irq_st", v, 32'h2);
    chk("irq_off", 32'(irq), 32'h0);
    wr(rom_access_pkg::ADDR_IRQ_MK, 32'h2);
    #1 chk("irq_on", 32'(irq), 32'h1);
    wr(rom_access_pkg::ADDR_IRQ_ST, 32'h2);
    #1 chk("irq_clr", 32'(irq), 32'h0);
    wa = 7'($random(seed));
    wd = 16'($random(seed));
    op(1'b1, wa, wd);
    op(1'b0, wa, 16'h0);
    op(1'b0, 7'($random(seed)), 16'h0);
    ack_en = 1'b0;
    wr(rom_access_pkg::ADDR_IRQ_ST, 32'h7);
    wr(rom_access_pkg::ADDR_CTRL, cw(1'b0, wa, wd, 2'h3, 1'b1));
    wait_clr();
    chk("nak_err", 32'(v[2]), 32'h1);
    rd(rom_access_pkg::ADDR_IRQ_ST);
    chk("nak_st", v, 32'h5);
    ack_en = 1'b1;
    rd(8'h7c);
    chk("unmapped", v, 32'h0);
    // Fast bit cleared in the first cycle: the load must run at the plain divided rate.
    do_reset(32'h30);
    per(128);
    rd(rom_access_pkg::ADDR_CTRL);
    chk("slow_load", v, 32'h130);
    for (int s = 0; s < 4; s++)
    begin
      do_reset(cw(1'b0, 7'h0, 16'h0, 2'(s), 1'b1) | 32'h40);
      rd(rom_access_pkg::ADDR_CTRL);
      chk("no_load", 32'(v[8]) + loads, LW);
      per(s < 3 ? 4096 >> s : 128);
    end
    end_sim();
  end
endmodule : serial_eeprom_access_control_bench
`default_nettype wire
